// [rtl/timer_pin_io_select_ch2_ch3.v]
`timescale 1ns/1ps
`include "pin_io_sel_regs.vh"
module timer_pin_io_select_ch2_ch3 #(
  parameter CNT_W = 16
) (
  input  wire             core_clk_i,
  input  wire             rstn_i,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output wire             pready,
  output reg  [31:0]      prdata,
  output wire             pslverr,
  input  wire             ch2_pin_a_i,
  input  wire             ch3_pin_a_i,
  input  wire             ch3_pin_c_i,
  input  wire             ch4_count_i,
  input  wire             ch2_match_a_i,
  input  wire             ch3_match_a_i,
  input  wire             ch3_match_c_i,
  input  wire [CNT_W-1:0] ch2_counter_i,
  input  wire [CNT_W-1:0] ch3_counter_i,
  output wire             ch2_pin_a_o,
  output wire             ch2_pin_a_oe_n_o,
  output wire             ch3_pin_a_o,
  output wire             ch3_pin_a_oe_n_o,
  output wire             ch3_pin_c_o,
  output wire             ch3_pin_c_oe_n_o,
  output wire             ch2_capture_a_o,
  output wire             ch3_capture_a_o,
  output wire             ch3_capture_c_o,
  output wire [CNT_W-1:0] ch2_general_reg_a_o,
  output wire [CNT_W-1:0] ch3_general_reg_a_o,
  output wire [CNT_W-1:0] ch3_general_reg_c_o
);
  reg  [7:0] pin_io_ctrl_ch2;
  reg  [7:0] pin_io_ctrl_ch3_high;
  reg  [7:0] pin_io_ctrl_ch3_low;
  reg  [7:0] ch3_mode_reg;
  reg        wr_ch2;
  reg        wr_ch3h;
  reg        wr_ch3l;
  reg        wr_mode;
  reg        addr_ok;
  wire [2:0] pins_sync;

  // Register selector codes
  localparam SEL_CH2    = 3'h0;
  localparam SEL_CH3H   = 3'h1;
  localparam SEL_CH3L   = 3'h2;
  localparam SEL_MODE   = 3'h3;
  localparam SEL_STATUS = 3'h4;
  localparam SEL_NONE   = 3'h7;

  // Maps a byte address onto a register selector, shared by write and read
  function [2:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr == `ADDR_CTRL_CH2)
        reg_sel = SEL_CH2;
      else if (addr == `ADDR_CTRL_CH3_HIGH)
        reg_sel = SEL_CH3H;
      else if (addr == `ADDR_CTRL_CH3_LOW)
        reg_sel = SEL_CH3L;
      else if (addr == `ADDR_CH3_MODE)
        reg_sel = SEL_MODE;
      else if (addr == `ADDR_STATUS)
        reg_sel = SEL_STATUS;
      else
        reg_sel = SEL_NONE;
    end
  endfunction

  // Function field seen by a unit; a landing write is seen in its own cycle,
  // so the initial pin level comes from the new field, not the old one
  function [3:0] live_field;
    input       wr;
    input [7:0] stored;
    input [7:0] wdata;
    begin
      if (wr)
        live_field = wdata[`FLD_A_HI:`FLD_A_LO];
      else
        live_field = stored[`FLD_A_HI:`FLD_A_LO];
    end
  endfunction

  // Selector and per-register function fields
  wire [2:0] sel           = reg_sel(paddr);
  wire       wr_en         = psel && penable && pwrite;
  wire       buffer_mode_a = ch3_mode_reg[`MODE_BUF_A];
  wire [3:0] fn_ch2_a      = live_field(wr_ch2, pin_io_ctrl_ch2, pwdata[7:0]);
  wire [3:0] fn_ch3_a      = live_field(wr_ch3h, pin_io_ctrl_ch3_high, pwdata[7:0]);
  wire [3:0] fn_ch3_c      = live_field(wr_ch3l, pin_io_ctrl_ch3_low, pwdata[7:0]);
  wire [3:0] fn_ch2_eff    = {fn_ch2_a[3], fn_ch2_a[3] ? 1'b0 : fn_ch2_a[2], fn_ch2_a[1:0]};

  // Zero-wait slave, errors on unmapped addresses
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Address decode
  always @* begin
    wr_ch2  = 1'b0;
    wr_ch3h = 1'b0;
    wr_ch3l = 1'b0;
    wr_mode = 1'b0;
    addr_ok = 1'b1;
    if (sel == SEL_CH2)
      wr_ch2 = wr_en;
    else if (sel == SEL_CH3H)
      wr_ch3h = wr_en;
    else if (sel == SEL_CH3L)
      wr_ch3l = wr_en;
    else if (sel == SEL_MODE)
      wr_mode = wr_en;
    else if (sel == SEL_STATUS)
      addr_ok = !pwrite;
    else
      addr_ok = 1'b0;
  end

  // Register writes
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pin_io_ctrl_ch2      <= `REG8_RESET;
      pin_io_ctrl_ch3_high <= `REG8_RESET;
      pin_io_ctrl_ch3_low  <= `REG8_RESET;
      ch3_mode_reg         <= `REG8_RESET;
    end else begin
      if (wr_ch2)
        pin_io_ctrl_ch2 <= pwdata[7:0];
      if (wr_ch3h)
        pin_io_ctrl_ch3_high <= pwdata[7:0];
      if (wr_ch3l)
        pin_io_ctrl_ch3_low <= pwdata[7:0];
      if (wr_mode)
        ch3_mode_reg <= pwdata[7:0];
    end
  end

  // Read data register, status shows pin levels and enables
  always @(posedge core_clk_i) begin
    if (!rstn_i)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      if (sel == SEL_CH2)
        prdata <= {24'h0, pin_io_ctrl_ch2};
      else if (sel == SEL_CH3H)
        prdata <= {24'h0, pin_io_ctrl_ch3_high};
      else if (sel == SEL_CH3L)
        prdata <= {24'h0, pin_io_ctrl_ch3_low};
      else if (sel == SEL_MODE)
        prdata <= {24'h0, ch3_mode_reg};
      else if (sel == SEL_STATUS)
        prdata <= {26'h0, !ch3_pin_c_oe_n_o, !ch3_pin_a_oe_n_o, !ch2_pin_a_oe_n_o,
                   ch3_pin_c_o, ch3_pin_a_o, ch2_pin_a_o};
      else
        prdata <= 32'h0;
    end
  end

  // Pin synchronisers
  sync2 #(.W(3)) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .d_i        ({ch3_pin_c_i, ch3_pin_a_i, ch2_pin_a_i}),
    .q_o        (pins_sync)
  );

  // Channel 2 register A, no count-event source
  pin_io_unit #(.CNT_W(CNT_W), .HAS_CH4SRC(0)) u_ch2_a (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .func_i      (fn_ch2_eff),
    .inhibit_i   (1'b0),
    .cfg_wr_i    (wr_ch2),
    .pin_sync_i  (pins_sync[0]),
    .ch4_count_i (1'b0),
    .match_i     (ch2_match_a_i),
    .counter_i   (ch2_counter_i),
    .pin_out_o   (ch2_pin_a_o),
    .pin_oe_n_o  (ch2_pin_a_oe_n_o),
    .capture_o   (ch2_capture_a_o),
    .capt_val_o  (ch2_general_reg_a_o)
  );

  // Channel 3 register A
  pin_io_unit #(.CNT_W(CNT_W), .HAS_CH4SRC(1)) u_ch3_a (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .func_i      (fn_ch3_a),
    .inhibit_i   (1'b0),
    .cfg_wr_i    (wr_ch3h),
    .pin_sync_i  (pins_sync[1]),
    .ch4_count_i (ch4_count_i),
    .match_i     (ch3_match_a_i),
    .counter_i   (ch3_counter_i),
    .pin_out_o   (ch3_pin_a_o),
    .pin_oe_n_o  (ch3_pin_a_oe_n_o),
    .capture_o   (ch3_capture_a_o),
    .capt_val_o  (ch3_general_reg_a_o)
  );

  // Channel 3 register C, inhibited in buffer mode
  pin_io_unit #(.CNT_W(CNT_W), .HAS_CH4SRC(1)) u_ch3_c (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .func_i      (fn_ch3_c),
    .inhibit_i   (buffer_mode_a),
    .cfg_wr_i    (wr_ch3l),
    .pin_sync_i  (pins_sync[2]),
    .ch4_count_i (ch4_count_i),
    .match_i     (ch3_match_c_i),
    .counter_i   (ch3_counter_i),
    .pin_out_o   (ch3_pin_c_o),
    .pin_oe_n_o  (ch3_pin_c_oe_n_o),
    .capture_o   (ch3_capture_c_o),
    .capt_val_o  (ch3_general_reg_c_o)
  );
endmodule // timer_pin_io_select_ch2_ch3

// [rtl/pin_io_sel_regs.vh]
`ifndef PIN_IO_SEL_REGS_VH
`define PIN_IO_SEL_REGS_VH
// Register byte addresses
`define ADDR_CTRL_CH2      12'h000
`define ADDR_CTRL_CH3_HIGH 12'h004
`define ADDR_CTRL_CH3_LOW  12'h008
`define ADDR_CH3_MODE      12'h00c
`define ADDR_STATUS        12'h010
// Function field layout
`define FLD_A_HI           7
`define FLD_A_LO           4
`define FLD_B_HI           3
`define FLD_B_LO           0
`define FB_CAPTURE         3
`define FB_INIT            2
`define FB_BOTH            1
`define FB_FALL            0
`define MODE_BUF_A         4
`define FIELD_RESET        4'h0
`define REG8_RESET         8'h00
`define ACT_NONE           2'h0
`define ACT_LOW            2'h1
`define ACT_HIGH           2'h2
`define ACT_TOGGLE         2'h3
`endif

// [rtl/pin_io_unit.v]
`timescale 1ns/1ps
`include "pin_io_sel_regs.vh"
// One general register's pin function: compare output or capture
module pin_io_unit #(
  parameter CNT_W      = 16,
  parameter HAS_CH4SRC = 1
) (
  input  wire             core_clk_i,
  input  wire             rstn_i,
  input  wire [3:0]       func_i,
  input  wire             inhibit_i,
  input  wire             cfg_wr_i,
  input  wire             pin_sync_i,
  input  wire             ch4_count_i,
  input  wire             match_i,
  input  wire [CNT_W-1:0] counter_i,
  output reg              pin_out_o,
  output wire             pin_oe_n_o,
  output reg              capture_o,
  output reg  [CNT_W-1:0] capt_val_o
);
  reg        pin_prev;
  reg        cap_evt;
  wire       is_cap   = func_i[`FB_CAPTURE];
  wire [1:0] act      = func_i[`FB_BOTH:`FB_FALL];
  wire       oc_on    = !inhibit_i && !is_cap && (act != `ACT_NONE);
  wire       rise     = pin_sync_i && !pin_prev;
  wire       fall     = !pin_sync_i && pin_prev;
  // Output enable is low while the pin is driven
  assign pin_oe_n_o = !oc_on;
  // Capture event selection
  always @* begin
    cap_evt = 1'b0;
    if (is_cap && !inhibit_i) begin
      if ((HAS_CH4SRC != 0) && func_i[`FB_INIT])
        cap_evt = ch4_count_i;
      else if (func_i[`FB_BOTH])
        cap_evt = rise || fall;
      else if (func_i[`FB_FALL])
        cap_evt = fall;
      else
        cap_evt = rise;
    end
  end
  // Pin level, edge history and capture register
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pin_prev   <= 1'b0;
      pin_out_o  <= 1'b0;
      capture_o  <= 1'b0;
      capt_val_o <= {CNT_W{1'b0}};
    end else begin
      pin_prev  <= pin_sync_i;
      capture_o <= cap_evt;
      if (cap_evt)
        capt_val_o <= counter_i;
      if (cfg_wr_i && !is_cap)
        pin_out_o <= func_i[`FB_INIT];
      else if (oc_on && match_i) begin
        case (act)
          `ACT_LOW:    pin_out_o <= 1'b0;
          `ACT_HIGH:   pin_out_o <= 1'b1;
          `ACT_TOGGLE: pin_out_o <= !pin_out_o;
          default:     pin_out_o <= pin_out_o;
        endcase
      end
    end
  end
endmodule // pin_io_unit

// [rtl/sync2.v]
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module sync2 #(
  parameter W = 3
) (
  input  wire         core_clk_i,
  input  wire         rstn_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta;
  // First stage feeds only the second
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // sync2

// [verif/pin_io_sel_monitor.sv]
`timescale 1ns/1ps
// Watches pin functions against shadow copies of the control fields
module pin_io_sel_monitor (
  input wire        core_clk_i,
  input wire        rstn_i,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        ch2_pin_a_i,
  input wire        ch3_pin_a_i,
  input wire        ch4_count_i,
  input wire        ch2_match_a_i,
  input wire        ch2_pin_a_o,
  input wire        ch2_pin_a_oe_n_o,
  input wire        ch3_pin_a_oe_n_o,
  input wire        ch3_pin_c_oe_n_o,
  input wire        ch2_capture_a_o,
  input wire        ch3_capture_a_o,
  input wire        ch3_capture_c_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire      wr = psel & penable & pwrite;
  wire      w2 = wr & (paddr == 12'h000);
  reg [3:0] f2;
  reg [3:0] f3a;
  reg       bufa;
  // Shadows follow completed writes, since a match loses to a write
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      f2 <= 4'h0;
      f3a <= 4'h0;
      bufa <= 1'b0;
    end else if (wr) begin
      if (paddr == 12'h000) f2 <= pwdata[7:4];
      if (paddr == 12'h004) f3a <= pwdata[7:4];
      if (paddr == 12'h00c) bufa <= pwdata[4];
    end
  end
  // Capture pulses come three edges after the pin edge: 2 sync flops and the capture register
  low_on_match_a: assert property (!f2[3] && f2[1:0] == 2'h1 && ch2_match_a_i && !w2
    |=> !ch2_pin_a_o)
    else $error("pin not low after match");
  high_on_match_a: assert property (!f2[3] && f2[1:0] == 2'h2 && ch2_match_a_i && !w2
    |=> ch2_pin_a_o)
    else $error("pin not high after match");
  toggle_match_a: assert property (!f2[3] && f2[1:0] == 2'h3 && ch2_match_a_i && !w2
    |=> ch2_pin_a_o != $past(ch2_pin_a_o))
    else $error("pin did not toggle");
  rise_capture_a: assert property (ch2_capture_a_o && f2[3] && f2[1:0] == 2'h0
    |-> $past(ch2_pin_a_i, 3) && !$past(ch2_pin_a_i, 4))
    else $error("capture without rising edge");
  fall_capture_a: assert property (ch3_capture_a_o && f3a == 4'h9
    |-> !$past(ch3_pin_a_i, 3) && $past(ch3_pin_a_i, 4))
    else $error("capture without falling edge");
  both_capture_a: assert property (ch3_capture_a_o && f3a[3:1] == 3'h5
    |-> $past(ch3_pin_a_i, 3) != $past(ch3_pin_a_i, 4))
    else $error("capture without pin edge");
  count_capture_a: assert property (f3a[3:2] == 2'h3 && ch4_count_i
    |-> ##1 ch3_capture_a_o)
    else $error("no capture on count");
  buffer_inhibit_a: assert property (bufa && $past(bufa, 3)
    |-> ch3_pin_c_oe_n_o && !ch3_capture_c_o)
    else $error("buffered register active");
  reset_idle_a: assert property (disable iff (1'b0) !rstn_i
    |=> ch2_pin_a_oe_n_o && ch3_pin_a_oe_n_o && !ch2_capture_a_o)
    else $error("pins active after reset");
endmodule // pin_io_sel_monitor

bind timer_pin_io_select_ch2_ch3 pin_io_sel_monitor i_pin_io_sel_monitor (.*);

// [verif/pin_wire_model.sv]
`timescale 1ns/1ps
// Pin wires: design level while it drives, else the external level
module pin_wire_model (
  input  wire [2:0] ext_i,
  input  wire [2:0] pin_o_i,
  input  wire [2:0] oe_n_i,
  output wire [2:0] wire_o
);
  // Each wire resolves from the design's enable
  assign wire_o = (oe_n_i & ext_i) | (~oe_n_i & pin_o_i);
endmodule // pin_wire_model

// [verif/timer_pin_io_select_ch2_ch3_test.sv]
`timescale 1ns/1ps
// Drives the registers over APB and the pins through the wire model
module timer_pin_io_select_ch2_ch3_test;
  reg         core_clk_i, rstn_i, psel, penable, pwrite, er;
  reg         ch2_match_a_i, ch3_match_a_i, ch3_match_c_i, ch4_count_i;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [15:0] ch2_counter_i, ch3_counter_i;
  reg  [2:0]  ext;
  wire        pready, pslverr, ch2_pin_a_i, ch3_pin_a_i, ch3_pin_c_i;
  wire        ch2_pin_a_o, ch3_pin_a_o, ch3_pin_c_o, ch2_capture_a_o, ch3_capture_a_o, ch3_capture_c_o;
  wire        ch2_pin_a_oe_n_o, ch3_pin_a_oe_n_o, ch3_pin_c_oe_n_o;
  wire [31:0] prdata;
  wire [15:0] ch2_general_reg_a_o, ch3_general_reg_a_o, ch3_general_reg_c_o;
  integer     bad_count, tests_run, i;

  timer_pin_io_select_ch2_ch3 i_timer_pin_io_select_ch2_ch3 (.*);
  pin_wire_model i_pin_wire_model (
    .ext_i   (ext),
    .pin_o_i ({ch3_pin_c_o, ch3_pin_a_o, ch2_pin_a_o}),
    .oe_n_i  ({ch3_pin_c_oe_n_o, ch3_pin_a_oe_n_o, ch2_pin_a_oe_n_o}),
    .wire_o  ({ch3_pin_c_i, ch3_pin_a_i, ch2_pin_a_i})
  );

  // Clock
  initial begin
    core_clk_i = 0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  task tally_and_finish;
    begin
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("BAD %0t saw %h expected %h", $time, s, e);
      end
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task xfer(input w, input [11:0] a, input [7:0] d);
    integer n;
    begin
      @(posedge core_clk_i);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk_i);
      penable <= 1;
      n = 0;
      @(posedge core_clk_i);
      while (!pready && n < 20) begin
        @(posedge core_clk_i);
        n = n + 1;
      end
      if (n == 20) begin
        bad_count = bad_count + 1;
        tally_and_finish;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      #1;
    end
  endtask

  // One-cycle pulse on {count, match c, match a3, match a2}
  task pls(input [3:0] v);
    begin
      @(posedge core_clk_i);
      {ch4_count_i, ch3_match_c_i, ch3_match_a_i, ch2_match_a_i} <= v;
      @(posedge core_clk_i);
      {ch4_count_i, ch3_match_c_i, ch3_match_a_i, ch2_match_a_i} <= 4'h0;
      repeat (2) @(posedge core_clk_i);
      #1;
    end
  endtask

  // Sets both counters and one external pin level, then lets it settle
  task pin(input integer k, input v, input [15:0] n);
    begin
      @(posedge core_clk_i);
      ext[k] <= v;
      ch2_counter_i <= n;
      ch3_counter_i <= n;
      repeat (8) @(posedge core_clk_i);
      #1;
    end
  endtask

  initial begin
    {rstn_i, psel, penable, pwrite, paddr, pwdata, ext} = 0;
    {ch4_count_i, ch3_match_c_i, ch3_match_a_i, ch2_match_a_i} = 4'h0;
    {ch2_counter_i, ch3_counter_i, bad_count, tests_run} = 0;
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1;
    for (i = 0; i < 3; i = i + 1) begin
      xfer(0, 12'(4 * i), 8'h00);
      chk(rd, 0);
    end
    chk({ch2_pin_a_oe_n_o, ch3_pin_a_oe_n_o, ch3_pin_c_oe_n_o}, 3'h7);
    // Every compare code: initial level, then the action on a match
    for (i = 0; i < 8; i = i + 1) begin
      xfer(1, 12'h000, {i[3:0], 4'h0});
      chk(ch2_pin_a_oe_n_o, i[1:0] == 2'h0);
      if (i[1:0] != 2'h0) begin
        chk(ch2_pin_a_o, i[2]);
        pls(4'h1);
        chk(ch2_pin_a_o, i[1:0] == 2'h1 ? 1'b0 : i[1:0] == 2'h2 ? 1'b1 : !i[2]);
      end
    end
    // Initial level comes from the field just written, not the previous one
    xfer(1, 12'h000, 8'h10);
    chk(ch2_pin_a_o, 0);
    // Capture edges and sources
    xfer(1, 12'h000, 8'hc0);
    pin(0, 1, 16'h1234);
    chk(ch2_general_reg_a_o, 16'h1234);
    pin(0, 0, 16'h5555);
    chk(ch2_general_reg_a_o, 16'h1234);
    xfer(1, 12'h004, 8'h90);
    pin(1, 1, 16'h0abc);
    chk(ch3_general_reg_a_o, 0);
    pin(1, 0, 16'h0bcd);
    chk(ch3_general_reg_a_o, 16'h0bcd);
    xfer(1, 12'h004, 8'ha0);
    pin(1, 1, 16'h1111);
    chk(ch3_general_reg_a_o, 16'h1111);
    pin(1, 0, 16'h2222);
    chk(ch3_general_reg_a_o, 16'h2222);
    xfer(1, 12'h004, 8'hc0);
    pin(2, 0, 16'h3333);
    pls(4'h8);
    chk(ch3_general_reg_a_o, 16'h3333);
    // Channel 3 register A as a toggling compare output
    xfer(1, 12'h004, 8'h30);
    chk(ch3_pin_a_o, 0);
    pls(4'h2);
    chk(ch3_pin_a_o, 1);
    // Buffer mode silences register C
    xfer(1, 12'h008, 8'ha0);
    xfer(1, 12'h00c, 8'h10);
    pin(2, 1, 16'h4444);
    chk(ch3_general_reg_c_o, 0);
    xfer(1, 12'h00c, 8'h00);
    pin(2, 0, 16'h5555);
    chk(ch3_general_reg_c_o, 16'h5555);
    xfer(1, 12'h008, 8'h20);
    pls(4'h4);
    chk(ch3_pin_c_o, 1);
    // Status: drive enables c, a3, a2 then levels c, a3, a2
    xfer(0, 12'h010, 8'h00);
    chk(rd, 32'h0000_0036);
    xfer(1, 12'h00c, 8'h10);
    chk(ch3_pin_c_oe_n_o, 1);
    // Read-back and an unmapped address
    xfer(0, 12'h004, 8'h00);
    chk(rd, 32'h0000_0030);
    xfer(0, 12'h020, 8'h00);
    chk(er, 1);
    chk(rd, 0);
    tally_and_finish;
  end
endmodule // timer_pin_io_select_ch2_ch3_test
